/* irq_flag_mask_edge_unit.sv */
// What this block does
// - Upper edge-select pair picks capture-pin edge, lower pair fifth line; 00/01/10/11.
// - Upper edge-select register is four write-only bits, all zero after reset.
// - External line mask 0 passes its flag's request, 1 blocks it.
// - Timer A overflow sets the timer A flag at bit 2.
// - Timer A mask at bit 3 blocks when 1, passes when 0.
// - Timer B overflow sets the timer B flag at bit 0.
// - Timer B mask at bit 1 blocks the timer B request when 1.
// - Timer C overflow sets the timer C flag at bit 2.
// - Timer C mask at bit 3 blocks the timer C request when 1.
// - Timer D overflow, or selected capture-pin edge under capture, sets timer D flag.
// - Timer D mask at bit 1 blocks the timer D request when 1.
// - Serial transfer end or suspension sets the serial flag at bit 2.
// - Serial mask at bit 3 blocks when 1, passes when 0.
// - A/D conversion end sets the A/D flag at bit 2.
// - A/D mask at bit 3 blocks when 1, passes when 0.
// - Request needs flag 1 and mask 0; taken only with global enable 1.
// - Software only clears flags; reset clears flags and enable, sets masks.
// - Fixed priority 1 to 7; paired sources share one vector.
// - Taking an interrupt clears global enable; return instruction sets it again.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_mask_edge_unit
  import irq_unit_pkg::*;
(
  input wire logic CLOCK_IN,                          // System clock, 50 MHz
  input wire logic RST_N_IN,                          // Chip reset, async, active low
  input wire irq_unit_pkg::cpu_bus_t BUS_IN,          // CPU bit access to control locations
  input wire irq_unit_pkg::periph_evt_t EVT_IN,       // Peripheral event pulses
  input wire logic CAPTURE_EN_IN,                     // Timer D input capture in use
  input wire logic [4:0] EXT_LINE_N_IN,               // External interrupt pins, active low
  input wire logic TIMER_D_EVENT_PIN_IN,              // Timer D event pin
  input wire logic IRQ_ACK_IN,                        // CPU takes the pending interrupt
  input wire logic RETURN_FROM_IRQ_INSTR_IN,          // Return-from-interrupt executed
  output logic [irq_unit_pkg::DATA_W-1:0] RDATA_OUT,  // Read data, one cycle after rd
  output logic IRQ_REQ_OUT,                           // Enabled request pending
  output logic [2:0] IRQ_PRIO_OUT,                    // Winning priority, 0 when none
  output logic [irq_unit_pkg::VEC_W-1:0] IRQ_VECTOR_OUT, // Vector address of winner
  output logic GLOBAL_IRQ_ENABLE_OUT                  // Global enable state
);
  import irq_unit_pkg::*;

  irq_state_t q;
  irq_state_t next_q;

  logic [NUM_PINS-1:0] edge_pulse;
  logic [NUM_PINS-1:0][1:0] edge_sel;
  logic [NUM_CTL-1:0][DATA_W-1:0] set_evt;
  logic [NUM_GROUPS-1:0] grp;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [2:0] win;
  logic wr_bit;

  // Decodes a control-nibble address; used by both write and read paths
  function automatic logic [2:0] ctl_index(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_CTL0: ctl_index = IDX_CTL0;
      ADDR_CTL1: ctl_index = IDX_EXT1_TIMER_A;
      ADDR_CTL2: ctl_index = IDX_TIMER_B_C;
      ADDR_CTL3: ctl_index = IDX_TIMER_D_ADC;
      ADDR_CTL22: ctl_index = IDX_EXT2_EXT3;
      ADDR_CTL23: ctl_index = IDX_EXT4_SERIAL;
      default: ctl_index = IDX_NONE;
    endcase
  endfunction : ctl_index

  // Lines 0 and 1 always detect falling edges; the others follow the selectors
  always_comb
  begin
    edge_sel = '0;
    edge_sel[PIN_EXT0] = EDGE_FALL;
    edge_sel[PIN_EXT1] = EDGE_FALL;
    edge_sel[PIN_EXT2] = q.esr_low[1:0];
    edge_sel[PIN_EXT3] = q.esr_low[3:2];
    edge_sel[PIN_EXT4] = q.esr_high[1:0];
    edge_sel[PIN_TIMER_D_EVENT] = q.esr_high[3:2];
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++)
    begin : g_pin
      logic raw_pin;
      assign raw_pin = (gp == PIN_TIMER_D_EVENT) ? TIMER_D_EVENT_PIN_IN : EXT_LINE_N_IN[gp % 5];
      // Every pin, capture input included, gets its own synchroniser; lines 0 and 1 have a fixed falling-edge select
      pin_edge_detect pin_edge_detect_i (
        .clock_in(CLOCK_IN),
        .rst_n_in(RST_N_IN),
        .pin_in(raw_pin),
        .sel_in(edge_sel_t'(edge_sel[gp])),
        .edge_out(edge_pulse[gp])
      );
    end
  endgenerate

  // Hardware set events, placed at the flag positions of each nibble
  always_comb
  begin
    set_evt = '0;
    set_evt[IDX_CTL0][BIT_HI_FLAG] = edge_pulse[PIN_EXT0];
    set_evt[IDX_EXT1_TIMER_A][BIT_LO_FLAG] = edge_pulse[PIN_EXT1];
    set_evt[IDX_EXT1_TIMER_A][BIT_HI_FLAG] = EVT_IN.tmr_a_ovf;
    set_evt[IDX_TIMER_B_C][BIT_LO_FLAG] = EVT_IN.tmr_b_ovf;
    set_evt[IDX_TIMER_B_C][BIT_HI_FLAG] = EVT_IN.tmr_c_ovf;
    set_evt[IDX_TIMER_D_ADC][BIT_LO_FLAG] = EVT_IN.tmr_d_ovf |
      (CAPTURE_EN_IN & edge_pulse[PIN_TIMER_D_EVENT]);
    set_evt[IDX_TIMER_D_ADC][BIT_HI_FLAG] = EVT_IN.adc_done;
    set_evt[IDX_EXT2_EXT3][BIT_LO_FLAG] = edge_pulse[PIN_EXT2];
    set_evt[IDX_EXT2_EXT3][BIT_HI_FLAG] = edge_pulse[PIN_EXT3];
    set_evt[IDX_EXT4_SERIAL][BIT_LO_FLAG] = edge_pulse[PIN_EXT4];
    set_evt[IDX_EXT4_SERIAL][BIT_HI_FLAG] = EVT_IN.serial_done | EVT_IN.serial_abort;
  end

  // Active request per priority group: flag 1 and mask 0
  always_comb
  begin
    grp[0] = q.ctl[IDX_CTL0][BIT_HI_FLAG] & ~q.ctl[IDX_CTL0][BIT_HI_MASK];
    grp[1] = q.ctl[IDX_EXT1_TIMER_A][BIT_LO_FLAG] & ~q.ctl[IDX_EXT1_TIMER_A][BIT_LO_MASK];
    grp[2] = q.ctl[IDX_EXT1_TIMER_A][BIT_HI_FLAG] &
      ~q.ctl[IDX_EXT1_TIMER_A][BIT_HI_MASK];
    grp[3] = (q.ctl[IDX_TIMER_B_C][BIT_LO_FLAG] & ~q.ctl[IDX_TIMER_B_C][BIT_LO_MASK]) |
      (q.ctl[IDX_EXT2_EXT3][BIT_LO_FLAG] & ~q.ctl[IDX_EXT2_EXT3][BIT_LO_MASK]);
    grp[4] = (q.ctl[IDX_TIMER_B_C][BIT_HI_FLAG] & ~q.ctl[IDX_TIMER_B_C][BIT_HI_MASK]) |
      (q.ctl[IDX_EXT2_EXT3][BIT_HI_FLAG] & ~q.ctl[IDX_EXT2_EXT3][BIT_HI_MASK]);
    grp[5] = (q.ctl[IDX_TIMER_D_ADC][BIT_LO_FLAG] & ~q.ctl[IDX_TIMER_D_ADC][BIT_LO_MASK]) |
      (q.ctl[IDX_EXT4_SERIAL][BIT_LO_FLAG] & ~q.ctl[IDX_EXT4_SERIAL][BIT_LO_MASK]);
    grp[6] = (q.ctl[IDX_TIMER_D_ADC][BIT_HI_FLAG] & ~q.ctl[IDX_TIMER_D_ADC][BIT_HI_MASK]) |
      (q.ctl[IDX_EXT4_SERIAL][BIT_HI_FLAG] & ~q.ctl[IDX_EXT4_SERIAL][BIT_HI_MASK]);
  end

  // Lowest group number wins
  always_comb
  begin
    win = 3'h0;
    for (int k = NUM_GROUPS - 1; k >= 0; k--)
    begin
      if (grp[k])
      begin
        win = 3'(k + 1);
      end
    end
  end

  assign wr_idx = BUS_IN.wr ? ctl_index(BUS_IN.addr) : IDX_NONE;
  assign rd_idx = ctl_index(BUS_IN.addr);

  always_comb
  begin
    next_q = q;
    wr_bit = 1'b0;
    for (int i = 0; i < NUM_CTL; i++)
    begin
      for (int b = 0; b < DATA_W; b++)
      begin
        wr_bit = (wr_idx == 3'(i)) && BUS_IN.wmask[b];
        if ((b % 2) == 0)
        begin
          // Writing 0 clears, writing 1 keeps; a same-cycle event still sets
          next_q.ctl[i][b] = set_evt[i][b] |
            (q.ctl[i][b] & ~(wr_bit & ~BUS_IN.wdata[b]));
        end
        else
        begin
          next_q.ctl[i][b] = wr_bit ? BUS_IN.wdata[b] : q.ctl[i][b];
        end
      end
    end
    // Bit 0 of the first nibble is the global enable, not a flag
    if (IRQ_ACK_IN)
    begin
      next_q.ctl[IDX_CTL0][BIT_ENABLE] = 1'b0;
    end
    else if (RETURN_FROM_IRQ_INSTR_IN)
    begin
      next_q.ctl[IDX_CTL0][BIT_ENABLE] = 1'b1;
    end
    else if ((wr_idx == IDX_CTL0) && BUS_IN.wmask[BIT_ENABLE])
    begin
      next_q.ctl[IDX_CTL0][BIT_ENABLE] = BUS_IN.wdata[BIT_ENABLE];
    end
    else
    begin
      next_q.ctl[IDX_CTL0][BIT_ENABLE] = q.ctl[IDX_CTL0][BIT_ENABLE];
    end
    next_q.ctl[IDX_CTL0][BIT_RESERVED] = 1'b0;
    if (BUS_IN.wr && (BUS_IN.addr == ADDR_EDGE_SEL_LOW))
    begin
      next_q.esr_low = BUS_IN.wdata;
    end
    if (BUS_IN.wr && (BUS_IN.addr == ADDR_EDGE_SEL_HIGH))
    begin
      next_q.esr_high = BUS_IN.wdata;
    end
    // Edge selectors are write-only and read back as zero
    if (BUS_IN.rd)
    begin
      next_q.rdata = (rd_idx == IDX_NONE) ? 4'h0 : q.ctl[rd_idx];
    end
    // One cycle of latency keeps every output on a flip-flop
    next_q.req = q.ctl[IDX_CTL0][BIT_ENABLE] & (|grp);
    next_q.prio = win;
    next_q.vec = {12'h000, win, 1'b0};
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      q <= '{ctl: {CTL_RESET, CTL_RESET, CTL_RESET, CTL_RESET, CTL_RESET, CTL0_RESET},
             esr_low: EDGE_SEL_RESET,
             esr_high: EDGE_SEL_RESET,
             rdata: 4'h0,
             req: 1'b0,
             prio: 3'h0,
             vec: 16'h0000};
    end
    else
    begin
      q <= next_q;
    end
  end

  assign RDATA_OUT = q.rdata;
  assign IRQ_REQ_OUT = q.req;
  assign IRQ_PRIO_OUT = q.prio;
  assign IRQ_VECTOR_OUT = q.vec;
  assign GLOBAL_IRQ_ENABLE_OUT = q.ctl[IDX_CTL0][BIT_ENABLE];

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  chk_edge_sel_fifth: assert property (
    edge_pulse[PIN_EXT4] |-> $past(q.esr_high[1:0]) != 2'b00)
    else $error("fifth line edge reported with detection off");

  chk_edge_sel_capture: assert property (
    edge_pulse[PIN_TIMER_D_EVENT] |-> $past(q.esr_high[3:2]) != 2'b00)
    else $error("capture edge reported with detection off");

  chk_ta_flag_set: assert property (
    EVT_IN.tmr_a_ovf |=> q.ctl[IDX_EXT1_TIMER_A][BIT_HI_FLAG])
    else $error("timer A overflow did not set its flag");

  chk_tb_flag_set: assert property (
    EVT_IN.tmr_b_ovf |=> q.ctl[IDX_TIMER_B_C][BIT_LO_FLAG])
    else $error("timer B overflow did not set its flag");

  chk_tc_flag_set: assert property (
    EVT_IN.tmr_c_ovf |=> q.ctl[IDX_TIMER_B_C][BIT_HI_FLAG])
    else $error("timer C overflow did not set its flag");

  chk_td_capture_set: assert property (
    (EVT_IN.tmr_d_ovf || (CAPTURE_EN_IN && edge_pulse[PIN_TIMER_D_EVENT]))
      |=> q.ctl[IDX_TIMER_D_ADC][BIT_LO_FLAG])
    else $error("timer D event did not set its flag");

  chk_serial_flag_set: assert property (
    (EVT_IN.serial_done || EVT_IN.serial_abort) |=> q.ctl[IDX_EXT4_SERIAL][BIT_HI_FLAG])
    else $error("serial event did not set its flag");

  chk_adc_flag_set: assert property (
    EVT_IN.adc_done |=> q.ctl[IDX_TIMER_D_ADC][BIT_HI_FLAG])
    else $error("conversion end did not set its flag");

  chk_flag_hw_only: assert property (
    $rose(q.ctl[IDX_EXT1_TIMER_A][BIT_HI_FLAG]) |-> $past(EVT_IN.tmr_a_ovf))
    else $error("timer A flag set without an overflow");

  chk_mask_blocks_ta: assert property (
    (q.ctl[IDX_EXT1_TIMER_A][BIT_HI_MASK] && (grp[1:0] == 2'b00) && (grp[6:3] == 4'h0))
      |=> !IRQ_REQ_OUT)
    else $error("masked timer A still requested");

  chk_ext_mask_blocks: assert property (
    (q.ctl[IDX_EXT4_SERIAL][BIT_LO_MASK] && q.ctl[IDX_TIMER_D_ADC][BIT_LO_MASK] &&
     (grp[4:0] == 5'h00) && !grp[6]) |=> !IRQ_REQ_OUT)
    else $error("masked fifth line still requested");

  // A group whose two members are both masked can never be the winner
  chk_tb_mask_blocks: assert property (
    (q.ctl[IDX_TIMER_B_C][BIT_LO_MASK] && q.ctl[IDX_EXT2_EXT3][BIT_LO_MASK])
      |=> (IRQ_PRIO_OUT != 3'h4))
    else $error("masked timer B group still won");

  chk_tc_mask_blocks: assert property (
    (q.ctl[IDX_TIMER_B_C][BIT_HI_MASK] && q.ctl[IDX_EXT2_EXT3][BIT_HI_MASK])
      |=> (IRQ_PRIO_OUT != 3'h5))
    else $error("masked timer C group still won");

  chk_td_mask_blocks: assert property (
    (q.ctl[IDX_TIMER_D_ADC][BIT_LO_MASK] && q.ctl[IDX_EXT4_SERIAL][BIT_LO_MASK])
      |=> (IRQ_PRIO_OUT != 3'h6))
    else $error("masked timer D group still won");

  chk_adc_mask_blocks: assert property (
    (q.ctl[IDX_TIMER_D_ADC][BIT_HI_MASK] && q.ctl[IDX_EXT4_SERIAL][BIT_HI_MASK])
      |=> (IRQ_PRIO_OUT != 3'h7))
    else $error("masked conversion group still won");

  chk_req_needs_enable: assert property (
    IRQ_REQ_OUT |-> $past(q.ctl[IDX_CTL0][BIT_ENABLE]) && ($past(grp) != 7'h00))
    else $error("request raised without enable or active source");

  chk_prio_order: assert property (
    (IRQ_PRIO_OUT == 3'h3) |-> ($past(grp[1:0]) == 2'b00) && $past(grp[2]))
    else $error("priority 3 granted over a higher source");

  chk_vector_pair: assert property (
    IRQ_VECTOR_OUT == {12'h000, IRQ_PRIO_OUT, 1'b0})
    else $error("vector does not match priority");

  chk_ack_clears_enable: assert property (
    IRQ_ACK_IN |=> !GLOBAL_IRQ_ENABLE_OUT ##1 !IRQ_REQ_OUT)
    else $error("enable or request survived acknowledge");

  chk_return_sets_enable: assert property (
    (RETURN_FROM_IRQ_INSTR_IN && !IRQ_ACK_IN) |=> GLOBAL_IRQ_ENABLE_OUT)
    else $error("return instruction did not set enable");

  chk_sw_set_refused: assert property (
    $rose(q.ctl[IDX_TIMER_B_C][BIT_LO_FLAG]) |-> $past(EVT_IN.tmr_b_ovf))
    else $error("timer B flag set without an overflow");

  chk_pin_edge_flag: assert property (
    edge_pulse[PIN_EXT4] |=> q.ctl[IDX_EXT4_SERIAL][BIT_LO_FLAG])
    else $error("fifth line edge did not set its flag");

  chk_line0_wins: assert property (
    grp[0] |=> (IRQ_PRIO_OUT == 3'h1))
    else $error("first external line lost priority");

  chk_read_wo_zero: assert property (
    (BUS_IN.rd && (rd_idx == IDX_NONE)) |=> (RDATA_OUT == 4'h0))
    else $error("write-only or unmapped location read nonzero");

  cov_group7_request: cover property (IRQ_REQ_OUT && (IRQ_PRIO_OUT == 3'h7));
  cov_ack_after_req: cover property (IRQ_REQ_OUT ##1 IRQ_ACK_IN);
  cov_capture_set: cover property (CAPTURE_EN_IN && edge_pulse[PIN_TIMER_D_EVENT]);
  cov_both_edges: cover property ((q.esr_high[1:0] == 2'b11) && edge_pulse[PIN_EXT4]);
  cov_line0_request: cover property (IRQ_REQ_OUT && (IRQ_PRIO_OUT == 3'h1));

endmodule : irq_flag_mask_edge_unit
`default_nettype wire

/* irq_flag_mask_edge_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_flag_mask_edge_unit_tb_top;
  import irq_unit_pkg::*;
  logic clock;
  logic rst_n;
  cpu_bus_t bus;
  periph_evt_t evt;
  logic capture_en;
  logic [4:0] line_n;
  logic event_pin;
  logic ack;
  logic ret;
  logic [DATA_W-1:0] rdata;
  logic req;
  logic [2:0] prio;
  logic [VEC_W-1:0] vec;
  logic enable;
  int errors;
  int compares;
  int i;
  int c;
  logic [ADDR_W-1:0] ca [5] = '{ADDR_CTL1, ADDR_CTL2, ADDR_CTL3, ADDR_CTL22, ADDR_CTL23};
  int kk [7] = '{6, 5, 4, 3, 0, 2, 1};
  logic [ADDR_W-1:0] ea [7] = '{ADDR_CTL1, ADDR_CTL2, ADDR_CTL2, ADDR_CTL3, ADDR_CTL3,
    ADDR_CTL23, ADDR_CTL23};
  logic [3:0] ev [7] = '{4'hE, 4'hB, 4'hF, 4'hB, 4'hF, 4'hE, 4'hE};
  logic [ADDR_W-1:0] ma [6] = '{ADDR_CTL3, ADDR_CTL23, ADDR_CTL3, ADDR_CTL2, ADDR_CTL2,
    ADDR_CTL1};
  logic [3:0] mm [6] = '{4'h8, 4'h8, 4'h2, 4'h8, 4'h2, 4'h8};
  logic [2:0] mp [6] = '{3'h7, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3};

  irq_flag_mask_edge_unit irq_flag_mask_edge_unit_i (
    .CLOCK_IN(clock),
    .RST_N_IN(rst_n),
    .BUS_IN(bus),
    .EVT_IN(evt),
    .CAPTURE_EN_IN(capture_en),
    .EXT_LINE_N_IN(line_n),
    .TIMER_D_EVENT_PIN_IN(event_pin),
    .IRQ_ACK_IN(ack),
    .RETURN_FROM_IRQ_INSTR_IN(ret),
    .RDATA_OUT(rdata),
    .IRQ_REQ_OUT(req),
    .IRQ_PRIO_OUT(prio),
    .IRQ_VECTOR_OUT(vec),
    .GLOBAL_IRQ_ENABLE_OUT(enable)
  );

  periph_pin_model periph_pin_model_i (
    .clock_in(clock),
    .evt_out(evt),
    .line_n_out(line_n),
    .event_pin_out(event_pin)
  );

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic end_of_test;
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [9:0] a, input logic [3:0] d, input logic [3:0] m);
    @(negedge clock);
    bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d, wmask: m};
    @(negedge clock);
    bus = '0;
  endtask : wr

  // Sampled a cycle late; the read value stands until the next read
  task automatic rd_chk(input logic [9:0] a, input logic [3:0] e, input string n);
    @(negedge clock);
    bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 4'h0, wmask: 4'h0};
    @(negedge clock);
    bus = '0;
    @(negedge clock);
    check(n, {12'h000, rdata}, {12'h000, e});
  endtask : rd_chk

  task automatic wait_req;
    int n = 0;
    while (req !== 1'b1 && n < 10)
    begin
      @(negedge clock);
      n++;
    end
    if (req !== 1'b1)
    begin
      errors++;
      end_of_test();
    end
  endtask : wait_req

  task automatic pulse(input logic is_ack);
    @(negedge clock);
    if (is_ack)
      ack = 1'b1;
    else
      ret = 1'b1;
    @(negedge clock);
    ack = 1'b0;
    ret = 1'b0;
  endtask : pulse

  initial
  begin
    rst_n = 1'b0;
    bus = '0;
    capture_en = 1'b0;
    ack = 1'b0;
    ret = 1'b0;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    check("req", {15'h0000, req}, 16'h0000);
    check("enable", {15'h0000, enable}, 16'h0000);
    rd_chk(ADDR_CTL0, CTL0_RESET, "ctl0");
    for (i = 0; i < 5; i++)
      rd_chk(ca[i], CTL_RESET, "ctl");
    rd_chk(ADDR_EDGE_SEL_HIGH, 4'h0, "edge sel");
    rd_chk(10'h3FF, 4'h0, "unmapped");
    wr(ADDR_CTL1, 4'h5, 4'h5);
    rd_chk(ADDR_CTL1, CTL_RESET, "sw set");
    for (i = 0; i < 7; i++)
    begin
      if (i == 6)
        wr(ADDR_CTL23, 4'h0, 4'h4);
      periph_pin_model_i.fire(kk[i]);
      rd_chk(ea[i], ev[i], "event flag");
    end
    wr(ADDR_CTL0, 4'h1, 4'h1);
    repeat (3) @(negedge clock);
    check("all masked", {13'h0000, prio}, 16'h0000);
    for (i = 0; i < 6; i++)
    begin
      wr(ma[i], 4'h0, mm[i]);
      wait_req();
      check("prio", {13'h0000, prio}, {13'h0000, mp[i]});
      check("vector", vec, {12'h000, mp[i], 1'b0});
      wr(ma[i], mm[i], mm[i]);
      repeat (3) @(negedge clock);
      check("masked", {15'h0000, req}, 16'h0000);
    end
    wr(ADDR_CTL1, 4'h0, 4'h8);
    wr(ADDR_CTL23, 4'h0, 4'h8);
    wait_req();
    check("winner", vec, 16'h0006);
    pulse(1'b1);
    check("ack enable", {15'h0000, enable}, 16'h0000);
    @(negedge clock);
    check("ack req", {15'h0000, req}, 16'h0000);
    pulse(1'b0);
    check("return", {15'h0000, enable}, 16'h0001);
    wr(ADDR_CTL1, 4'h8, 4'h8);
    wr(ADDR_CTL23, 4'h8, 4'h8);
    capture_en = 1'b1;
    wr(ADDR_CTL3, 4'h0, 4'h1);
    periph_pin_model_i.pins(5'h0F, 1'b0);
    periph_pin_model_i.pins(5'h1F, 1'b1);
    rd_chk(ADDR_CTL3, 4'hE, "no edge");
    rd_chk(ADDR_CTL23, 4'hE, "no edge");
    for (c = 0; c < 4; c++)
    begin
      wr(ADDR_EDGE_SEL_HIGH, {c[1:0], c[1:0]}, 4'hF);
      wr(ADDR_CTL3, 4'h0, 4'h1);
      wr(ADDR_CTL23, 4'h0, 4'h1);
      periph_pin_model_i.pins(5'h0F, 1'b0);
      rd_chk(ADDR_CTL3, {3'b111, c[0]}, "capture fall");
      rd_chk(ADDR_CTL23, {3'b111, c[0]}, "line4 fall");
      wr(ADDR_CTL3, 4'h0, 4'h1);
      wr(ADDR_CTL23, 4'h0, 4'h1);
      periph_pin_model_i.pins(5'h1F, 1'b1);
      rd_chk(ADDR_CTL3, {3'b111, c[1]}, "capture rise");
      rd_chk(ADDR_CTL23, {3'b111, c[1]}, "line4 rise");
    end
    capture_en = 1'b0;
    wr(ADDR_CTL3, 4'h0, 4'h1);
    periph_pin_model_i.pins(5'h1F, 1'b0);
    rd_chk(ADDR_CTL3, 4'hE, "capture off");
    wr(ADDR_CTL23, 4'h0, 4'h2);
    wait_req();
    check("line4 prio", {13'h0000, prio}, 16'h0006);
    wr(ADDR_CTL23, 4'h2, 4'h2);
    repeat (3) @(negedge clock);
    check("line4 masked", {15'h0000, req}, 16'h0000);
    wr(ADDR_EDGE_SEL_LOW, 4'h5, 4'hF);
    periph_pin_model_i.pins(5'h00, 1'b0);
    rd_chk(ADDR_CTL0, 4'hD, "line0 fall");
    rd_chk(ADDR_CTL1, 4'hF, "line1 fall");
    rd_chk(ADDR_CTL22, 4'hF, "line2 line3 fall");
    wr(ADDR_CTL0, 4'h0, 4'h8);
    wr(ADDR_CTL1, 4'h0, 4'h2);
    wait_req();
    check("line0 vector", vec, 16'h0002);
    wr(ADDR_CTL0, 4'h8, 4'h8);
    repeat (3) @(negedge clock);
    check("line1 prio", {13'h0000, prio}, 16'h0002);
    wr(ADDR_CTL1, 4'h2, 4'h2);
    repeat (3) @(negedge clock);
    check("lines masked", {15'h0000, req}, 16'h0000);
    end_of_test();
  end
endmodule : irq_flag_mask_edge_unit_tb_top
`default_nettype wire

/* irq_unit_pkg.sv */
`default_nettype none
package irq_unit_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 4;
  localparam int VEC_W = 16;
  localparam int NUM_CTL = 6;
  localparam int NUM_PINS = 6;
  localparam int NUM_GROUPS = 7;

  // Control-bit locations as seen by the CPU's bit instructions
  localparam logic [ADDR_W-1:0] ADDR_CTL0 = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_CTL1 = 10'h001;
  localparam logic [ADDR_W-1:0] ADDR_CTL2 = 10'h002;
  localparam logic [ADDR_W-1:0] ADDR_CTL3 = 10'h003;
  localparam logic [ADDR_W-1:0] ADDR_CTL22 = 10'h022;
  localparam logic [ADDR_W-1:0] ADDR_CTL23 = 10'h023;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL_LOW = 10'h026;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL_HIGH = 10'h027;

  // Index of each control nibble inside the state array
  localparam logic [2:0] IDX_CTL0 = 3'h0;
  localparam logic [2:0] IDX_EXT1_TIMER_A = 3'h1;
  localparam logic [2:0] IDX_TIMER_B_C = 3'h2;
  localparam logic [2:0] IDX_TIMER_D_ADC = 3'h3;
  localparam logic [2:0] IDX_EXT2_EXT3 = 3'h4;
  localparam logic [2:0] IDX_EXT4_SERIAL = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // Field positions: flag on even bit, its mask on the odd bit above
  localparam int BIT_ENABLE = 0;
  localparam int BIT_RESERVED = 1;
  localparam int BIT_LO_FLAG = 0;
  localparam int BIT_LO_MASK = 1;
  localparam int BIT_HI_FLAG = 2;
  localparam int BIT_HI_MASK = 3;

  // Pin index of each edge detector
  localparam int PIN_EXT0 = 0;
  localparam int PIN_EXT1 = 1;
  localparam int PIN_EXT2 = 2;
  localparam int PIN_EXT3 = 3;
  localparam int PIN_EXT4 = 4;
  localparam int PIN_TIMER_D_EVENT = 5;

  // Reset values: flags and enable 0, masks 1
  localparam logic [DATA_W-1:0] CTL0_RESET = 4'h8;
  localparam logic [DATA_W-1:0] CTL_RESET = 4'hA;
  localparam logic [DATA_W-1:0] EDGE_SEL_RESET = 4'h0;
  localparam logic PIN_IDLE = 1'b1;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] wmask;
  } cpu_bus_t;

  typedef struct packed {
    logic tmr_a_ovf;
    logic tmr_b_ovf;
    logic tmr_c_ovf;
    logic tmr_d_ovf;
    logic serial_done;
    logic serial_abort;
    logic adc_done;
  } periph_evt_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic pulse;
  } edge_state_t;

  typedef struct packed {
    logic [NUM_CTL-1:0][DATA_W-1:0] ctl;
    logic [DATA_W-1:0] esr_low;
    logic [DATA_W-1:0] esr_high;
    logic [DATA_W-1:0] rdata;
    logic req;
    logic [2:0] prio;
    logic [VEC_W-1:0] vec;
  } irq_state_t;

  function automatic logic edge_hit(input edge_sel_t sel, input logic rise);
    case (sel)
      EDGE_FALL: edge_hit = ~rise;
      EDGE_RISE: edge_hit = rise;
      EDGE_BOTH: edge_hit = 1'b1;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

endpackage : irq_unit_pkg
`default_nettype wire

/* periph_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module periph_pin_model
  import irq_unit_pkg::*;
(
  input wire logic clock_in,                     // System clock
  output irq_unit_pkg::periph_evt_t evt_out,     // Peripheral event pulses
  output logic [4:0] line_n_out,                 // External pins, idle high
  output logic event_pin_out                     // Timer D event pin
);
  initial
  begin
    evt_out = '0;
    line_n_out = 5'h1F;
    event_pin_out = 1'b1;
  end

  // One-cycle strobe, as an overflow or a finished transfer gives it
  task automatic fire(input int k);
    @(negedge clock_in);
    evt_out[k] = 1'b1;
    @(negedge clock_in);
    evt_out[k] = 1'b0;
  endtask : fire

  // Pins are held long enough to pass the synchroniser and the compare
  task automatic pins(input logic [4:0] lines, input logic ev);
    @(negedge clock_in);
    line_n_out = lines;
    event_pin_out = ev;
    repeat (8) @(negedge clock_in);
  endtask : pins
endmodule : periph_pin_model
`default_nettype wire

/* pin_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect
  import irq_unit_pkg::*;
(
  input wire logic clock_in,                      // System clock
  input wire logic rst_n_in,                      // Asynchronous reset, active low
  input wire logic pin_in,                        // Raw pin level
  input wire irq_unit_pkg::edge_sel_t sel_in,     // Edge to report
  output logic edge_out                           // One-cycle pulse per qualifying edge
);
  import irq_unit_pkg::*;

  edge_state_t q;
  edge_state_t next_q;

  always_comb
  begin
    next_q = q;
    next_q.s1 = pin_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.pulse = 1'b0;
    // A level counts only once two later stages agree; s1 only feeds s2 and stays out of the compare
    if ((q.s2 == q.s3) && (q.s2 != q.level))
    begin
      next_q.level = q.s2;
      next_q.pulse = edge_hit(sel_in, q.s2);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, level: PIN_IDLE, pulse: 1'b0};
    end
    else
    begin
      q <= next_q;
    end
  end

  assign edge_out = q.pulse;

endmodule : pin_edge_detect
`default_nettype wire
